// ===== design/byte_rotate_datapath.sv
// byte rotate datapath with file addressing and register slave
`timescale 1ns/100ps
// Behaviour
// - left rotate no carry: msb to bit0
// - right rotate through carry, carry from bit0
// - d=0 writes working reg, d=1 file
// - a=0 access bank, a=1 bank select register
// - extended, a=0, f<=95 uses indexed offset
// - indexed offset only with extended set enabled
// - left rotate through carry, bit7 to carry
module byte_rotate_datapath (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // instruction from decoder
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    output logic             o_busy,
    // data memory register file
    output logic [11:0]      o_mem_addr,
    output logic             o_mem_rd,
    input  wire logic [7:0]  i_mem_rdata,
    output logic             o_mem_wr,
    output logic [7:0]       o_mem_wdata,
    // working register and flags
    output logic [7:0]       o_wreg,
    output logic             o_carry,
    output logic             o_zero,
    output logic             o_negative,
    // axi4-lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    rot_pkg::seq_t    state_ff;
    logic             busy_ff;
    logic [5:0]       op_ff;
    logic             dest_ff;
    logic [11:0]      addr_ff;
    logic             rd_ff;
    logic             wr_ff;
    logic [7:0]       wdat_ff;
    logic             ext_ff;
    logic [3:0]       bank_ff;
    logic [7:0]       wreg_ff;
    logic [2:0]       flags_ff;
    logic [11:0]      index_ff;
    logic             aw_got_ff;
    logic             w_got_ff;
    logic [7:0]       awaddr_ff;
    logic [31:0]      wd_ff;
    logic [3:0]       ws_ff;
    logic             awready_ff;
    logic             wready_ff;
    logic             bvalid_ff;
    logic [1:0]       bresp_ff;
    logic             arready_ff;
    logic             rvalid_ff;
    logic [31:0]      rdata_ff;
    logic [1:0]       rresp_ff;

    // instruction fields
    wire logic [5:0]  in_op   = i_instr[15:10];
    wire logic        in_d    = i_instr[rot_pkg::INSTR_D_BIT];
    wire logic        in_a    = i_instr[rot_pkg::INSTR_A_BIT];
    wire logic [7:0]  in_f    = i_instr[7:0];
    wire logic        op_ok   = (in_op == rot_pkg::OP_RLNC) ||
                                (in_op == rot_pkg::OP_RRC) ||
                                (in_op == rot_pkg::OP_RLC);
    // unsupported opcodes are left for other units, never taken here
    wire logic        accept  = i_instr_valid && !busy_ff && op_ok;

    // effective file address
    wire logic        use_idx = ext_ff && !in_a &&
                                (in_f <= rot_pkg::IDX_LIMIT);
    // offset wraps inside the 12-bit file space, carry out dropped on purpose
    wire logic [11:0] idx_adr = 12'(index_ff + {4'h0, in_f});
    wire logic [3:0]  acc_bnk = (in_f > rot_pkg::IDX_LIMIT) ?
                                rot_pkg::ACC_HIGH_BANK :
                                rot_pkg::ACC_LOW_BANK;
    wire logic [3:0]  sel_bnk = in_a ? bank_ff : acc_bnk;
    wire logic [11:0] eff_adr = use_idx ? idx_adr : {sel_bnk, in_f};

    // rotate unit on the fetched operand
    wire logic [7:0]  src     = i_mem_rdata;
    wire logic        c_in    = flags_ff[rot_pkg::FLAG_C_BIT];
    logic [7:0]       rot_res;
    logic             rot_c;
    always_comb begin
        rot_res = src;
        rot_c   = c_in;
        case (op_ff)
            rot_pkg::OP_RLNC: begin
                rot_res = {src[6:0], src[7]};
                rot_c   = c_in;
            end
            rot_pkg::OP_RRC: begin
                rot_res = {c_in, src[7:1]};
                rot_c   = src[0];
            end
            rot_pkg::OP_RLC: begin
                rot_res = {src[6:0], c_in};
                rot_c   = src[7];
            end
            default: begin
                rot_res = src;
                rot_c   = c_in;
            end
        endcase
    end
    wire logic        res_z   = (rot_res == 8'h00);
    wire logic        res_n   = rot_res[7];
    wire logic [2:0]  new_flg = {res_n, res_z, rot_c};
    wire logic        exec    = (state_ff == rot_pkg::ST_EXEC);

    // sequencer: fetch, then rotate and write back
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= rot_pkg::ST_IDLE;
            busy_ff  <= 1'b0;
            op_ff    <= 6'h00;
            dest_ff  <= 1'b0;
            addr_ff  <= 12'h000;
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            wdat_ff  <= 8'h00;
        end else if (i_ce) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            case (state_ff)
                rot_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_ff <= rot_pkg::ST_READ;
                        busy_ff  <= 1'b1;
                        op_ff    <= in_op;
                        dest_ff  <= in_d;
                        addr_ff  <= eff_adr;
                        rd_ff    <= 1'b1;
                    end
                end
                rot_pkg::ST_READ: begin
                    state_ff <= rot_pkg::ST_EXEC;
                end
                rot_pkg::ST_EXEC: begin
                    state_ff <= rot_pkg::ST_IDLE;
                    busy_ff  <= 1'b0;
                    wr_ff    <= dest_ff;
                    wdat_ff  <= rot_res;
                end
                default: begin
                    state_ff <= rot_pkg::ST_IDLE;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // bus write channel bookkeeping
    wire logic        aw_take   = i_awvalid && awready_ff;
    wire logic        w_take    = i_wvalid && wready_ff;
    wire logic        do_write  = aw_got_ff && w_got_ff && !bvalid_ff;
    wire logic        nxt_awgot = !do_write && (aw_got_ff || aw_take);
    wire logic        nxt_wgot  = !do_write && (w_got_ff || w_take);
    wire logic        nxt_bval  = do_write || (bvalid_ff && !i_bready);
    wire logic        wr_hit    = (awaddr_ff == rot_pkg::OFS_CTRL) ||
                                  (awaddr_ff == rot_pkg::OFS_BANK) ||
                                  (awaddr_ff == rot_pkg::OFS_WREG) ||
                                  (awaddr_ff == rot_pkg::OFS_FLAGS) ||
                                  (awaddr_ff == rot_pkg::OFS_INDEX) ||
                                  (awaddr_ff == rot_pkg::OFS_LAST);

    // byte lane mask from write strobes
    logic [31:0] wmask;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign wmask[gb*8 +: 8] = {8{ws_ff[gb]}};
        end
    endgenerate
    wire logic [31:0] wmerge = wd_ff & wmask;
    wire logic        wl0    = ws_ff[0];
    wire logic        wl1    = ws_ff[1];

    // software register writes; hardware updates win the same cycle
    wire logic sw_ctrl  = do_write && (awaddr_ff == rot_pkg::OFS_CTRL);
    wire logic sw_bank  = do_write && (awaddr_ff == rot_pkg::OFS_BANK);
    wire logic sw_wreg  = do_write && (awaddr_ff == rot_pkg::OFS_WREG);
    wire logic sw_flags = do_write && (awaddr_ff == rot_pkg::OFS_FLAGS);
    wire logic sw_index = do_write && (awaddr_ff == rot_pkg::OFS_INDEX);
    wire logic hw_wreg  = exec && !dest_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_ff   <= rot_pkg::RST_EXT;
            bank_ff  <= rot_pkg::RST_BANK;
            wreg_ff  <= rot_pkg::RST_WREG;
            flags_ff <= rot_pkg::RST_FLAGS;
            index_ff <= rot_pkg::RST_INDEX;
        end else if (i_ce) begin
            if (sw_ctrl && wl0)
                ext_ff <= wmerge[rot_pkg::CTRL_EXT_BIT];
            if (sw_bank && wl0)
                bank_ff <= wmerge[3:0];
            if (hw_wreg)
                wreg_ff <= rot_res;
            else if (sw_wreg && wl0)
                wreg_ff <= wmerge[7:0];
            if (exec && (op_ff == rot_pkg::OP_RLNC))
                flags_ff <= {res_n, res_z, c_in};
            else if (exec)
                flags_ff <= new_flg;
            else if (sw_flags && wl0)
                flags_ff <= wmerge[2:0];
            if (sw_index && wl0)
                index_ff[7:0] <= wmerge[7:0];
            if (sw_index && wl1)
                index_ff[11:8] <= wmerge[11:8];
        end
    end

    // write address, data and response channels
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awaddr_ff  <= 8'h00;
            wd_ff      <= 32'h0000_0000;
            ws_ff      <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= rot_pkg::RESP_OKAY;
        end else if (i_ce) begin
            aw_got_ff  <= nxt_awgot;
            w_got_ff   <= nxt_wgot;
            awready_ff <= !nxt_awgot && !nxt_bval;
            wready_ff  <= !nxt_wgot && !nxt_bval;
            bvalid_ff  <= nxt_bval;
            if (aw_take)
                awaddr_ff <= {i_awaddr[7:2], 2'b00};
            if (w_take) begin
                wd_ff <= i_wdata;
                ws_ff <= i_wstrb;
            end
            if (do_write) // unmapped offsets answer slverr
                bresp_ff <= wr_hit ? rot_pkg::RESP_OKAY :
                                     rot_pkg::RESP_SLVERR;
        end
    end

    // read decode
    wire logic [7:0] ar_word = {i_araddr[7:2], 2'b00};
    logic [31:0]     rd_val;
    logic            rd_hit;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ar_word)
            rot_pkg::OFS_CTRL:  rd_val = {31'h0, ext_ff};
            rot_pkg::OFS_BANK:  rd_val = {28'h0, bank_ff};
            rot_pkg::OFS_WREG:  rd_val = {24'h0, wreg_ff};
            rot_pkg::OFS_FLAGS: rd_val = {29'h0, flags_ff};
            rot_pkg::OFS_INDEX: rd_val = {20'h0, index_ff};
            rot_pkg::OFS_LAST:  rd_val = {19'h0, busy_ff, addr_ff};
            default:            rd_hit = 1'b0;
        endcase
    end
    wire logic ar_take  = i_arvalid && arready_ff;
    wire logic nxt_rval = ar_take || (rvalid_ff && !i_rready);

    // read address and data channels
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= rot_pkg::RESP_OKAY;
        end else if (i_ce) begin
            arready_ff <= !nxt_rval;
            rvalid_ff  <= nxt_rval;
            if (ar_take) begin
                rdata_ff <= rd_val;
                rresp_ff <= rd_hit ? rot_pkg::RESP_OKAY :
                                     rot_pkg::RESP_SLVERR;
            end
        end
    end

    // all outputs straight from flops
    assign o_busy      = busy_ff;
    assign o_mem_addr  = addr_ff;
    assign o_mem_rd    = rd_ff;
    assign o_mem_wr    = wr_ff;
    assign o_mem_wdata = wdat_ff;
    assign o_wreg      = wreg_ff;
    assign o_carry     = flags_ff[rot_pkg::FLAG_C_BIT];
    assign o_zero      = flags_ff[rot_pkg::FLAG_Z_BIT];
    assign o_negative  = flags_ff[rot_pkg::FLAG_N_BIT];
    assign o_awready   = awready_ff;
    assign o_wready    = wready_ff;
    assign o_bvalid    = bvalid_ff;
    assign o_bresp     = bresp_ff;
    assign o_arready   = arready_ff;
    assign o_rvalid    = rvalid_ff;
    assign o_rdata     = rdata_ff;
    assign o_rresp     = rresp_ff;
endmodule

// ===== design/rot_pkg.sv
// shared constants for the byte rotate datapath
package rot_pkg;
    // register bus geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          FADDR_W       = 12;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_BANK      = 8'h04;
    localparam logic [7:0]  OFS_WREG      = 8'h08;
    localparam logic [7:0]  OFS_FLAGS     = 8'h0C;
    localparam logic [7:0]  OFS_INDEX     = 8'h10;
    localparam logic [7:0]  OFS_LAST      = 8'h14;
    // field positions
    localparam int          CTRL_EXT_BIT  = 0;
    localparam int          FLAG_C_BIT    = 0;
    localparam int          FLAG_Z_BIT    = 1;
    localparam int          FLAG_N_BIT    = 2;
    localparam int          BANK_W        = 4;
    // reset values
    localparam logic        RST_EXT       = 1'b0;
    localparam logic [3:0]  RST_BANK      = 4'h0;
    localparam logic [7:0]  RST_WREG      = 8'h00;
    localparam logic [2:0]  RST_FLAGS     = 3'h0;
    localparam logic [11:0] RST_INDEX     = 12'h000;
    // opcode field, instruction bits 15..10
    localparam logic [5:0]  OP_RLNC       = 6'h11;
    localparam logic [5:0]  OP_RRC        = 6'h0C;
    localparam logic [5:0]  OP_RLC        = 6'h0D;
    localparam int          INSTR_D_BIT   = 9;
    localparam int          INSTR_A_BIT   = 8;
    // addressing limits
    localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
    localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
    localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
    // bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_EXEC = 3'b100
    } seq_t;
endpackage

// ===== tb/file_mem_model.sv
// data memory model answering the datapath's read and write pulses
`timescale 1ns/100ps
module file_mem_model (
    input  wire logic        i_clk,
    input  wire logic [11:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem [4096];
    initial o_rdata = 8'h5A;
    // data valid only in the cycle after a read pulse, scrambled otherwise
    // so a late sample of the bus cannot pass by luck
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_rdata <= mem[i_addr];
        end else begin
            o_rdata <= ~o_rdata;
        end
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule

// ===== tb/rot_chk.sv
// concurrent checks on the rotate datapath ports
`timescale 1ns/100ps
module rot_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic        o_busy,
    input wire logic        o_mem_rd,
    input wire logic [7:0]  i_mem_rdata,
    input wire logic        o_mem_wr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic [7:0]  o_wreg,
    input wire logic        o_carry,
    input wire logic        o_zero,
    input wire logic        o_negative,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [31:0] o_rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [5:0] op;
    logic       take;
    logic [5:0] op_ff;
    logic       d_ff;
    // instruction accepted at this edge
    assign op   = i_instr[15:10];
    assign take = i_ce && i_instr_valid && !o_busy &&
                  (op == rot_pkg::OP_RLNC || op == rot_pkg::OP_RRC ||
                   op == rot_pkg::OP_RLC);
    // opcode and destination kept, the decoder may move on meanwhile
    always_ff @(posedge i_clk) begin
        if (take) begin
            op_ff <= op;
            d_ff  <= i_instr[9];
        end
    end
    // expected {carry, result} from operand and carry before the op
    function automatic logic [8:0] rot(logic [5:0] k, logic [7:0] v,
                                       logic c);
        if (k == rot_pkg::OP_RLNC) return {c, v[6:0], v[7]};
        if (k == rot_pkg::OP_RRC) return {v[0], c, v[7:1]};
        return {v[7], v[6:0], c};
    endfunction
    sequence read_phase;
        o_mem_rd && o_busy ##1 !o_mem_rd && o_busy;
    endsequence
    sequence exec_done;
        !o_busy;
    endsequence
    take_seq_a: assert property (
        take |=> read_phase ##1 exec_done)
        else $error("rotate phases out of order");
    rd_cause_a: assert property (o_mem_rd |-> $past(take))
        else $error("read pulse without accepted instruction");
    wr_pulse_a: assert property (o_mem_wr |=> !o_mem_wr)
        else $error("write pulse longer than one cycle");
    dest_sel_a: assert property (
        $past(take, 3) |-> o_mem_wr == d_ff)
        else $error("write pulse does not follow destination bit");
    res_wreg_a: assert property (
        $past(take, 3) && !d_ff |->
        {o_carry, o_wreg} == rot(op_ff, $past(i_mem_rdata), $past(o_carry)))
        else $error("working register or carry wrong");
    res_file_a: assert property (
        $past(take, 3) && d_ff |->
        {o_carry, o_mem_wdata} == rot(op_ff, $past(i_mem_rdata),
                                      $past(o_carry)))
        else $error("file write data or carry wrong");
    flag_zn_a: assert property ($past(take, 3) |->
        o_negative == (d_ff ? o_mem_wdata[7] : o_wreg[7]) &&
        o_zero == ((d_ff ? o_mem_wdata : o_wreg) == 8'h00))
        else $error("zero or negative flag wrong");
    bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the byte rotate datapath
`timescale 1ns/100ps
module tb_top;
    localparam logic [1:0] OK = rot_pkg::RESP_OKAY;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_ce = 1'b1;
    logic        i_instr_valid = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0]  i_wstrb = 4'hF;
    logic [7:0]  i_mem_rdata, o_mem_wdata, o_wreg;
    logic [11:0] o_mem_addr;
    logic        o_busy, o_mem_rd, o_mem_wr, o_carry, o_zero, o_negative;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata;
    int          err_count = 0;
    int          num_checks = 0;
    always #4 i_clk = ~i_clk;
    byte_rotate_datapath dut (.i_clk, .i_rst, .i_ce, .i_instr_valid,
        .i_instr, .o_busy, .o_mem_addr, .o_mem_rd, .i_mem_rdata, .o_mem_wr,
        .o_mem_wdata, .o_wreg, .o_carry, .o_zero, .o_negative, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready);
    file_mem_model mem_m (.i_clk, .i_addr(o_mem_addr), .i_rd(o_mem_rd),
        .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one write, address and data offered together, each released when taken
    task automatic bus_wr(logic [7:0] a, logic [31:0] d, logic [1:0] rsp);
        logic done;
        done = 1'b0;
        @(posedge i_clk);
        i_awaddr  <= a;
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid && i_bready) begin
                done = 1'b1;
                i_bready <= 1'b0;
                chk("bresp", rsp, o_bresp);
            end
        end
    endtask
    task automatic bus_rd(logic [7:0] a, logic [31:0] exp, logic [1:0] rsp);
        logic done;
        done = 1'b0;
        @(posedge i_clk);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid && i_rready) begin
                done = 1'b1;
                i_rready <= 1'b0;
                chk("rdata", exp, o_rdata);
                chk("rresp", rsp, o_rresp);
            end
        end
    endtask
    // one instruction; extra cycle lets the memory model land its write
    task automatic run(logic [5:0] op, logic d, logic a, logic [7:0] f,
                       logic [11:0] ea, logic [7:0] res, logic [2:0] nzc);
        @(posedge i_clk);
        i_instr       <= {op, d, a, f};
        i_instr_valid <= 1'b1;
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        chk("mem_addr", ea, o_mem_addr);
        chk("busy", 1'b0, o_busy);
        if (d) chk("file", res, mem_m.mem[ea]);
        else chk("wreg", res, o_wreg);
        chk("flags", nzc, {o_negative, o_zero, o_carry});
    endtask
    // reset values, read-only and unmapped places
    task automatic t_regs();
        bus_rd(rot_pkg::OFS_CTRL, 32'h0000_0000, OK);
        bus_rd(rot_pkg::OFS_WREG, 32'h0000_0000, OK);
        bus_rd(rot_pkg::OFS_FLAGS, 32'h0000_0000, OK);
        bus_wr(rot_pkg::OFS_LAST, 32'h0000_0FFF, OK);
        bus_rd(rot_pkg::OFS_LAST, 32'h0000_0000, OK);
        bus_wr(8'h18, 32'h0000_0001, rot_pkg::RESP_SLVERR);
        bus_rd(8'h18, 32'h0000_0000, rot_pkg::RESP_SLVERR);
        // only lane 1 enabled: upper index nibble lands, low byte stays
        i_wstrb <= 4'h2;
        bus_wr(rot_pkg::OFS_INDEX, 32'h0000_0ABC, OK);
        i_wstrb <= 4'hF;
        bus_rd(rot_pkg::OFS_INDEX, 32'h0000_0A00, OK);
    endtask
    // carry set beforehand must survive the no-carry rotate
    task automatic t_rlnc();
        bus_wr(rot_pkg::OFS_BANK, 32'h0000_0005, OK);
        bus_wr(rot_pkg::OFS_FLAGS, 32'h0000_0001, OK);
        mem_m.mem[12'h5A7] = 8'hAB;
        run(rot_pkg::OP_RLNC, 1'b1, 1'b1,
            8'hA7, 12'h5A7, 8'h57, 3'b001);
        bus_rd(rot_pkg::OFS_LAST, 32'h0000_05A7, OK);
    endtask
    // indexed offset at the 0x5F edge, not at 0x60, not with bank bit set
    task automatic t_index();
        bus_wr(rot_pkg::OFS_CTRL, 32'h0000_0001, OK);
        bus_wr(rot_pkg::OFS_INDEX, 32'h0000_0123, OK);
        mem_m.mem[12'h182] = 8'h02;
        run(rot_pkg::OP_RRC, 1'b1, 1'b0,
            8'h5F, 12'h182, 8'h81, 3'b100);
        mem_m.mem[12'hF60] = 8'h80;
        run(rot_pkg::OP_RLNC, 1'b1, 1'b0,
            8'h60, 12'hF60, 8'h01, 3'b000);
        mem_m.mem[12'h510] = 8'h00;
        run(rot_pkg::OP_RLC, 1'b0, 1'b1,
            8'h10, 12'h510, 8'h00, 3'b010);
    endtask
    // extended set off with a nonzero index base: plain access bank
    task automatic t_rlc();
        bus_wr(rot_pkg::OFS_CTRL, 32'h0000_0000, OK);
        bus_wr(rot_pkg::OFS_FLAGS, 32'h0000_0000, OK);
        mem_m.mem[12'h020] = 8'hE6;
        run(rot_pkg::OP_RLC, 1'b0, 1'b0,
            8'h20, 12'h020, 8'hCC, 3'b101);
        chk("file_kept", 8'hE6, mem_m.mem[12'h020]);
        bus_rd(rot_pkg::OFS_WREG, 32'h0000_00CC, OK);
    endtask
    // upper access bank, zero result with carry out
    task automatic t_rrc();
        bus_wr(rot_pkg::OFS_FLAGS, 32'h0000_0000, OK);
        mem_m.mem[12'hF80] = 8'h01;
        run(rot_pkg::OP_RRC, 1'b0, 1'b0,
            8'h80, 12'hF80, 8'h00, 3'b011);
        bus_rd(rot_pkg::OFS_FLAGS, 32'h0000_0003, OK);
    endtask
    // frozen enable, then a foreign opcode: neither may touch any state
    task automatic t_ignore();
        @(posedge i_clk);
        i_ce          <= 1'b0;
        i_instr       <= {rot_pkg::OP_RLC, 2'b00, 8'h20};
        i_instr_valid <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_ce          <= 1'b1;
        i_instr       <= {6'h10, 2'b00, 8'h20};
        repeat (4) @(posedge i_clk);
        i_instr_valid <= 1'b0;
        #1;
        chk("wreg_kept", 8'h00, o_wreg);
        chk("flg_kept", 3'b011, {o_negative, o_zero, o_carry});
        chk("busy_idle", 1'b0, o_busy);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_rlnc();
        t_index();
        t_rlc();
        t_rrc();
        t_ignore();
        tally_and_finish();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        err_count++;
        tally_and_finish();
    end
endmodule
bind byte_rotate_datapath rot_chk chk (.i_clk, .i_rst, .i_ce, .i_instr_valid,
    .i_instr, .o_busy, .o_mem_rd, .i_mem_rdata, .o_mem_wr, .o_mem_wdata,
    .o_wreg, .o_carry, .o_zero, .o_negative, .o_bvalid, .i_bready,
    .o_rvalid, .i_rready, .o_rdata);
